// ===== core/image_chunk_frame_counter.sv
// Appends trailing chunks to each image and keeps frame/trigger counters.
// Assumes pixel words arrive with valid/ready/last and the sink may stall.
`timescale 1ns/1ps
`default_nettype none
module image_chunk_frame_counter
    import chunk_pkg::*;
#(
    parameter int CW = chunk_pkg::CNT_W
) (
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       chunk_master_on,
    input  wire logic [chunk_pkg::PICK_W-1:0] chunk_pick,
    input  wire logic                       chunk_switch,
    input  wire logic                       chunk_switch_wr,
    input  wire logic [1:0]                 counter_pick,
    input  wire logic [1:0]                 counter_count_trigger,
    input  wire logic [1:0]                 counter_clear_origin,
    input  wire logic                       counter_clear_origin_wr,
    input  wire logic                       counter_clear_cmd,
    input  wire logic                       input_line_one,
    input  wire logic                       input_line_two,
    input  wire logic                       frame_begin_event,
    input  wire logic                       ext_trigger,
    input  wire logic [15:0]                roi_offset_x,
    input  wire logic [15:0]                roi_offset_y,
    input  wire logic [15:0]                roi_width,
    input  wire logic [15:0]                roi_height,
    input  wire logic [31:0]                pixel_format,
    input  wire logic [15:0]                dyn_range_min,
    input  wire logic [15:0]                dyn_range_max,
    input  wire logic [31:0]                pix_data,
    input  wire logic                       pix_valid,
    input  wire logic                       pix_last,
    output logic                            pix_ready,
    output logic [31:0]                     out_data,
    output logic                            out_valid,
    output logic                            out_last,
    input  wire logic                       out_ready,
    output logic                            payload_kind,
    output logic [chunk_pkg::NCHUNK-1:0]    chunk_enables,
    output logic                            ext_chunk_on,
    output logic [1:0]                      clear_origin_now,
    output logic [CW-1:0]                   frame_number_chunk_value,
    output logic [CW-1:0]                   trigger_count_value
);
    typedef enum logic [1:0] {S_PIX, S_EXT, S_FRAME, S_TRIG} tx_state_e;

    logic [NCHUNK-1:0] en_q;
    logic              master_q;
    clear_origin_e     origin_q;
    logic [CW-1:0]     frame_q;
    logic [CW-1:0]     trig_q;
    logic              input_line_one_q;
    logic              input_line_two_q;
    logic              clear_hit;
    logic              clear_frame;
    logic              clear_trig;
    tx_state_e         st_q;
    logic [2:0]        idx_q;
    logic [CW-1:0]     frame_snap_q;
    logic [CW-1:0]     trig_snap_q;
    logic              snap_q;
    logic [31:0]       ext_rd;
    logic [2:0]        st_waddr;
    logic [31:0]       st_wdata;
    logic              hs;

    // Wraps naturally; kept as a function so both counters share it
    function automatic logic [CW-1:0] bump(input logic [CW-1:0] v);
        return (v == CW'(CNT_MAX)) ? '0 : v + CW'(1);
    endfunction

    // ************************************************************
    // Chunk switches
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            en_q     <= '0;
            master_q <= 1'b0;
        end else begin
            master_q <= chunk_master_on;
            if (!chunk_master_on) begin
                en_q <= '0;
            end else if (chunk_switch_wr && chunk_pick < PICK_W'(NCHUNK)) begin
                en_q[chunk_pick] <= chunk_switch;
            end
        end
    end

    assign chunk_enables = en_q;
    assign ext_chunk_on  = master_q;
    assign payload_kind  = master_q ? PAYLOAD_CHUNK : PAYLOAD_IMAGE;

    // ************************************************************
    // Clear origin and line edges
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            origin_q <= CLR_OFF;
            input_line_one_q  <= 1'b0;
            input_line_two_q  <= 1'b0;
        end else begin
            if (counter_clear_origin_wr) begin
                origin_q <= clear_origin_e'(counter_clear_origin);
            end
            input_line_one_q <= input_line_one;
            input_line_two_q <= input_line_two;
        end
    end
    assign clear_origin_now = origin_q;

    always_comb begin
        case (origin_q)
            CLR_SOFT: clear_hit = counter_clear_cmd;
            CLR_ONE:  clear_hit = input_line_one & ~input_line_one_q;
            CLR_TWO:  clear_hit = input_line_two & ~input_line_two_q;
            default:  clear_hit = 1'b0;
        endcase
    end

    // Host configures the picked instance before the origin
    assign clear_frame = clear_hit && counter_pick == CTR_SECOND
                         && counter_count_trigger == EVT_FRAME_BEGIN;
    assign clear_trig  = clear_hit && counter_pick == CTR_FIRST
                         && counter_count_trigger == EVT_FRAME_TRIGGER;

    // ************************************************************
    // Counters
    // ************************************************************
    // Every frame begin counts, delivered or not, except in a cycle where clear_frame also fires
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            frame_q <= CW'(FRAME_CNT_RST);
        end else if (clear_frame) begin
            frame_q <= '0;
        end else if (frame_begin_event) begin
            frame_q <= bump(frame_q);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            trig_q <= CW'(TRIG_CNT_RST);
        end else if (clear_trig) begin
            trig_q <= '0;
        end else if (ext_trigger) begin
            trig_q <= bump(trig_q);
        end
    end

    assign frame_number_chunk_value = frame_q;
    assign trigger_count_value      = trig_q;

    // ************************************************************
    // Per-frame snapshot
    // ************************************************************
    // Values taken at frame begin, before the count moves on
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            frame_snap_q <= '0;
            trig_snap_q  <= '0;
            snap_q       <= 1'b0;
        end else begin
            snap_q <= frame_begin_event;
            if (frame_begin_event) begin
                frame_snap_q <= frame_q;
                trig_snap_q  <= trig_q;
            end
        end
    end

    // ROI, pixel format and dynamic range words written one per cycle from a small counter
    logic [2:0] wr_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_q <= '0;
        end else if (wr_q == 3'(EXT_WORDS - 1)) begin
            wr_q <= '0;
        end else begin
            wr_q <= wr_q + 3'h1;
        end
    end
    assign st_waddr = wr_q;

    always_comb begin
        case (wr_q)
            3'h0:    st_wdata = {16'h0000, roi_offset_x};
            3'h1:    st_wdata = {16'h0000, roi_offset_y};
            3'h2:    st_wdata = {16'h0000, roi_width};
            3'h3:    st_wdata = {16'h0000, roi_height};
            3'h4:    st_wdata = pixel_format;
            3'h5:    st_wdata = {16'h0000, dyn_range_min};
            3'h6:    st_wdata = {16'h0000, dyn_range_max};
            default: st_wdata = 32'h0000_0000;
        endcase
    end

    // Store is rewritten only outside the chunk tail, so words stay stable
    chunk_store #(.WIDTH(WORD_W), .DEPTH(8)) u_store (
        .core_clk (core_clk),
        .we       (st_q == S_PIX),
        .waddr    (st_waddr),
        .wdata    (st_wdata),
        .raddr    (idx_q),
        .rdata    (ext_rd)
    );

    // ************************************************************
    // Output stream
    // ************************************************************
    // Registered word plus a registered read; one idle cycle per extended chunk word is traded
    // for simple timing on the memory path; the frame and trigger words have none.
    logic [2:0]  cnt_q;
    logic        pend_q;
    assign hs        = out_valid && out_ready;
    assign pix_ready = (st_q == S_PIX) && (!out_valid || out_ready);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q      <= S_PIX;
            idx_q     <= '0;
            cnt_q     <= '0;
            pend_q    <= 1'b0;
            out_data  <= 32'h0000_0000;
            out_valid <= 1'b0;
            out_last  <= 1'b0;
        end else begin
            if (hs) begin
                out_valid <= 1'b0;
                out_last  <= 1'b0;
            end
            case (st_q)
                S_PIX: begin
                    idx_q <= '0;
                    if (pix_valid && pix_ready) begin
                        out_data  <= pix_data;
                        out_valid <= 1'b1;
                        out_last  <= pix_last && !master_q;
                        if (pix_last && master_q) begin
                            st_q   <= S_EXT;
                            cnt_q  <= '0;
                            pend_q <= 1'b0;
                        end
                    end
                end
                S_EXT: begin
                    if (!pend_q) begin
                        pend_q <= 1'b1;
                    end else if (!out_valid || out_ready) begin
                        out_data  <= ext_rd;
                        out_valid <= 1'b1;
                        pend_q    <= 1'b0;
                        if (cnt_q == 3'(EXT_WORDS - 1)) begin
                            out_last <= !en_q[PICK_FRAME] && !en_q[PICK_TRIG];
                            if (en_q[PICK_FRAME]) begin
                                st_q <= S_FRAME;
                            end else if (en_q[PICK_TRIG]) begin
                                st_q <= S_TRIG;
                            end else begin
                                st_q <= S_PIX;
                            end
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                            idx_q <= cnt_q + 3'h1;
                        end
                    end
                end
                S_FRAME: begin
                    if (!out_valid || out_ready) begin
                        out_data  <= 32'(frame_snap_q);
                        out_valid <= 1'b1;
                        out_last  <= !en_q[PICK_TRIG];
                        st_q      <= en_q[PICK_TRIG] ? S_TRIG : S_PIX;
                    end
                end
                S_TRIG: begin
                    if (!out_valid || out_ready) begin
                        out_data  <= 32'(trig_snap_q);
                        out_valid <= 1'b1;
                        out_last  <= 1'b1;
                        st_q      <= S_PIX;
                    end
                end
                default: st_q <= S_PIX;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== core/chunk_pkg.sv
// Constants and types shared by the chunk appender and its testbench.
// Assumes a single 40 MHz core clock; no bus, all settings are ports.
package chunk_pkg;

    // ************************************************************
    // Widths and values after reset
    // ************************************************************
    localparam int CNT_W = 32;
    localparam logic [31:0] FRAME_CNT_RST = 32'h0000_0000;
    localparam logic [31:0] TRIG_CNT_RST  = 32'h0000_0001;
    localparam logic [31:0] CNT_MAX       = 32'hffff_ffff;
    localparam int WORD_W = 32;
    localparam int PICK_W = 3;
    localparam int NCHUNK = 6;

    // ************************************************************
    // Chunk picks, which are also enable bit positions
    // ************************************************************
    localparam logic [2:0] PICK_FRAME   = 3'h0;
    localparam logic [2:0] PICK_TRIG    = 3'h1;
    localparam logic [2:0] PICK_STAMP   = 3'h2;
    localparam logic [2:0] PICK_LINES   = 3'h3;
    localparam logic [2:0] PICK_CHECK   = 3'h4;
    localparam logic [2:0] PICK_SEQIDX  = 3'h5;

    // ************************************************************
    // Counter instances, count triggers, clear origins
    // ************************************************************
    localparam logic [1:0] CTR_FIRST  = 2'h1;
    localparam logic [1:0] CTR_SECOND = 2'h2;
    localparam logic [1:0] EVT_FRAME_TRIGGER = 2'h1;
    localparam logic [1:0] EVT_FRAME_BEGIN   = 2'h2;
    typedef enum logic [1:0] {
        CLR_OFF  = 2'h0,
        CLR_SOFT = 2'h1,
        CLR_ONE  = 2'h2,
        CLR_TWO  = 2'h3
    } clear_origin_e;

    // Payload kind codes
    localparam logic PAYLOAD_IMAGE = 1'b0;
    localparam logic PAYLOAD_CHUNK = 1'b1;

    // Extended image data chunk layout, in words
    localparam int EXT_WORDS = 7;
    localparam logic [31:0] ID_EXT   = 32'h0000_0e01;
    localparam logic [31:0] ID_FRAME = 32'h0000_0e02;
    localparam logic [31:0] ID_TRIG  = 32'h0000_0e03;

endpackage

// ===== core/chunk_store.sv
// Small register file holding the settings latched for one frame.
// Assumes the writer gives one word per cycle; read data are registered.
`timescale 1ns/1ps
`default_nettype none
module chunk_store #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic                     core_clk,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [WIDTH-1:0]         wdata,
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output var  logic [WIDTH-1:0]         rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // ************************************************************
    // Storage
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ===== testbench/chunk_checker_assertions.sv
// Port checker for the chunk appender and its frame/trigger counters.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module chunk_checker #(
    parameter int CW = 32
) (
    input wire logic          core_clk,
    input wire logic          sys_rst,
    input wire logic          chunk_master_on,
    input wire logic          chunk_switch_wr,
    input wire logic [1:0]    counter_pick,
    input wire logic [1:0]    counter_count_trigger,
    input wire logic          counter_clear_cmd,
    input wire logic          input_line_one,
    input wire logic          frame_begin_event,
    input wire logic          ext_trigger,
    input wire logic          out_ready,
    input wire logic [31:0]   out_data,
    input wire logic          out_valid,
    input wire logic          out_last,
    input wire logic          payload_kind,
    input wire logic [5:0]    chunk_enables,
    input wire logic          ext_chunk_on,
    input wire logic [1:0]    clear_origin_now,
    input wire logic [CW-1:0] frame_number_chunk_value,
    input wire logic [CW-1:0] trigger_count_value
);
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    rst_vals_a: assert property ($fell(sys_rst) |->
        clear_origin_now == 2'h0 && frame_number_chunk_value == '0
        && trigger_count_value == 1) else $error("bad values after reset");
    ext_on_a: assert property ($rose(chunk_master_on) |=> ext_chunk_on)
        else $error("extended chunk not on");
    kind_follows_a: assert property (payload_kind ==
        ($past(chunk_master_on) && !$past(sys_rst)))
        else $error("payload kind wrong");
    enable_refused_a: assert property (chunk_switch_wr && !chunk_master_on
        && chunk_enables == '0 |=> chunk_enables == '0)
        else $error("enable taken while master off");
    master_clear_a: assert property (!chunk_master_on [*2]
        |=> chunk_enables == '0) else $error("enables kept");
    frame_step_a: assert property (frame_begin_event
        && clear_origin_now == 2'h0 |=> frame_number_chunk_value
        == $past(frame_number_chunk_value) + 1'b1) else $error("frame step");
    trig_step_a: assert property (ext_trigger
        && clear_origin_now == 2'h0 |=> trigger_count_value
        == $past(trigger_count_value) + 1'b1) else $error("trigger step");
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid
        && $stable(out_data) && $stable(out_last)) else $error("word dropped");
    soft_clear_a: assert property (clear_origin_now == 2'h1
        && counter_clear_cmd && counter_pick == 2'h2 && counter_count_trigger
        == 2'h2 |=> frame_number_chunk_value == '0) else $error("soft clear");
    line_clear_a: assert property (clear_origin_now == 2'h2
        && $rose(input_line_one) && counter_pick == 2'h2 && counter_count_trigger
        == 2'h2 |=> frame_number_chunk_value == '0) else $error("line clear");
    frame_end_c: cover property (out_valid && out_ready && out_last);
    soft_clear_c: cover property (clear_origin_now == 2'h1 && counter_clear_cmd);
    master_on_c: cover property ($rose(chunk_master_on));
endmodule
bind image_chunk_frame_counter chunk_checker #(.CW(CW)) u_chunk_checker (
    .core_clk, .sys_rst, .chunk_master_on, .chunk_switch_wr, .counter_pick,
    .counter_count_trigger, .counter_clear_cmd, .input_line_one,
    .frame_begin_event, .ext_trigger, .out_ready, .out_data, .out_valid,
    .out_last, .payload_kind, .chunk_enables, .ext_chunk_on, .clear_origin_now,
    .frame_number_chunk_value, .trigger_count_value);
`default_nettype wire

// ===== testbench/host_sink.sv
// Host side model: takes every output word, may stall every other cycle.
// Assumes the bench reads words and last_at by hierarchy.
`timescale 1ns/1ps
`default_nettype none
module host_sink (
    input wire logic        core_clk,
    input wire logic        slow,
    input wire logic [31:0] out_data,
    input wire logic        out_valid,
    input wire logic        out_last,
    output var logic        out_ready
);
    logic [31:0] words[$];
    int          last_at = -1;
    initial out_ready = 1'b1;
    // Stalling on alternate cycles exercises the hold of each word
    always @(negedge core_clk) out_ready <= !slow || !out_ready;
    always @(posedge core_clk) begin
        if (out_valid && out_ready) begin
            words.push_back(out_data);
            if (out_last) last_at = words.size() - 1;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tb_image_chunk_frame_counter.sv
// Self-checking bench for the chunk appender and its counters.
// Assumes chunk_pkg is compiled first; the host is modelled by host_sink.
`timescale 1ns/1ps
`default_nettype none
module tb_image_chunk_frame_counter;
    import chunk_pkg::*;
    logic        core_clk = 1'b0, sys_rst = 1'b1, chunk_master_on = 1'b0;
    logic        chunk_switch = 1'b0, chunk_switch_wr = 1'b0;
    logic [2:0]  chunk_pick = 3'h0;
    logic [1:0]  counter_pick = 2'h0, counter_count_trigger = 2'h0;
    logic [1:0]  counter_clear_origin = 2'h0, clear_origin_now;
    logic        counter_clear_origin_wr = 1'b0, counter_clear_cmd = 1'b0;
    logic        input_line_one = 1'b0, input_line_two = 1'b0, slow = 1'b0;
    logic        frame_begin_event = 1'b0, ext_trigger = 1'b0;
    logic [15:0] roi_offset_x = 16'h0012, roi_offset_y = 16'h0034;
    logic [15:0] roi_width = 16'h0280, roi_height = 16'h01e0;
    logic [15:0] dyn_range_min = 16'h0010, dyn_range_max = 16'h0fff;
    logic [31:0] pixel_format = 32'h0108_0001, pix_data = 32'h0;
    logic        pix_valid = 1'b0, pix_last = 1'b0, pix_ready, out_valid;
    logic        out_last, out_ready, payload_kind, ext_chunk_on;
    logic [31:0] out_data, frame_number_chunk_value, trigger_count_value;
    logic [31:0] fexp = 32'h0, texp = 32'h1;
    logic [5:0]  chunk_enables;
    int          n_errors = 0, tests_run = 0;
    image_chunk_frame_counter u_image_chunk_frame_counter (.core_clk, .sys_rst,
        .chunk_master_on, .chunk_pick, .chunk_switch, .chunk_switch_wr,
        .counter_pick, .counter_count_trigger, .counter_clear_origin,
        .counter_clear_origin_wr, .counter_clear_cmd, .input_line_one,
        .input_line_two, .frame_begin_event, .ext_trigger, .roi_offset_x,
        .roi_offset_y, .roi_width, .roi_height, .pixel_format, .dyn_range_min,
        .dyn_range_max, .pix_data, .pix_valid, .pix_last, .pix_ready, .out_data,
        .out_valid, .out_last, .out_ready, .payload_kind, .chunk_enables,
        .ext_chunk_on, .clear_origin_now, .frame_number_chunk_value,
        .trigger_count_value);
    host_sink u_host_sink (.core_clk, .slow, .out_data, .out_valid, .out_last,
        .out_ready);
    always #12.5 core_clk = ~core_clk;
    // ************************************************************
    // Helpers; all are entered at a falling edge, except the tick after the rising-edge wait in t_frame
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic en(input logic [2:0] p, input logic v);
        chunk_pick = p;
        chunk_switch = v;
        chunk_switch_wr = 1'b1;
        tick(1);
        chunk_switch_wr = 1'b0;
        tick(1);
    endtask
    task automatic origin(input logic [1:0] p, t, o);
        counter_pick = p;
        counter_count_trigger = t;
        counter_clear_origin = o;
        counter_clear_origin_wr = 1'b1;
        tick(1);
        counter_clear_origin_wr = 1'b0;
        tick(1);
    endtask
    task automatic ev(input logic f, t);
        frame_begin_event = f;
        ext_trigger = t;
        tick(1);
        frame_begin_event = 1'b0;
        ext_trigger = 1'b0;
        if (f) fexp++;
        if (t) texp++;
        tick(1);
        check(frame_number_chunk_value, fexp);
        check(trigger_count_value, texp);
    endtask
    task automatic fire(input int k);
        counter_clear_cmd = (k == 1);
        input_line_one = (k == 2);
        input_line_two = (k == 3);
        tick(1);
        counter_clear_cmd = 1'b0;
        input_line_one = 1'b0;
        input_line_two = 1'b0;
        tick(1);
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_master();
        check(frame_number_chunk_value, 32'h0);
        check(trigger_count_value, 32'h1);
        check({30'h0, clear_origin_now}, 32'h0);
        en(PICK_FRAME, 1'b1);
        check({26'h0, chunk_enables}, 32'h0);
        chunk_master_on = 1'b1;
        tick(2);
        check({31'h0, ext_chunk_on}, 32'h1);
        check({31'h0, payload_kind}, 32'h1);
        en(PICK_FRAME, 1'b1);
        en(PICK_TRIG, 1'b1);
        en(3'h6, 1'b1);
        check({26'h0, chunk_enables}, 32'h3);
        for (int p = 2; p < 6; p++) en(3'(p), 1'b1);
        check({26'h0, chunk_enables}, 32'h3f);
        chunk_master_on = 1'b0;
        tick(3);
        check({26'h0, chunk_enables}, 32'h0);
        $display("master switch test done");
    endtask
    task automatic t_frame(input logic on);
        logic [31:0] ex[$];
        ex = '{32'ha000_0000, 32'ha000_0001, 32'ha000_0002};
        if (on) ex = {ex, 32'(roi_offset_x), 32'(roi_offset_y),
            32'(roi_width), 32'(roi_height), pixel_format,
            32'(dyn_range_min), 32'(dyn_range_max), fexp, texp};
        check({31'h0, payload_kind}, 32'(on));
        u_host_sink.words.delete();
        u_host_sink.last_at = -1;
        ev(1'b1, 1'b1);
        slow = on;
        for (int i = 0; i < 3; i++) begin
            pix_data = 32'ha000_0000 + 32'(i);
            pix_valid = 1'b1;
            pix_last = (i == 2);
            // Ready is judged at the rising edge, after the sink's update
            do @(posedge core_clk); while (!pix_ready);
            tick(1);
        end
        pix_valid = 1'b0;
        pix_last = 1'b0;
        for (int i = 0; i < 200 && u_host_sink.last_at < 0; i++) tick(1);
        check(32'(u_host_sink.words.size()), 32'(ex.size()));
        foreach (ex[k]) check(u_host_sink.words[k], ex[k]);
        check(32'(u_host_sink.last_at), 32'(ex.size() - 1));
        $display("frame test done");
    endtask
    task automatic t_clear();
        ev(1'b0, 1'b1);
        ev(1'b1, 1'b0);
        for (int o = 1; o < 4; o++) begin
            origin(2'h2, 2'h2, 2'(o));
            ev(1'b1, 1'b0);
            for (int k = 1; k < 4; k++) if (k != o) fire(k);
            check(frame_number_chunk_value, fexp);
            fire(o);
            fexp = 32'h0;
            check(frame_number_chunk_value, fexp);
        end
        origin(2'h2, 2'h2, 2'h2);
        input_line_one = 1'b1;
        tick(2);
        fexp = 32'h0;
        ev(1'b1, 1'b0);
        ev(1'b1, 1'b0);
        input_line_one = 1'b0;
        origin(2'h1, 2'h1, 2'h1);
        fire(1);
        texp = 32'h0;
        check(trigger_count_value, texp);
        check(frame_number_chunk_value, fexp);
        origin(2'h2, 2'h2, 2'h0);
        fire(1);
        fire(2);
        check(frame_number_chunk_value, fexp);
        $display("counter clear test done");
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Whole run is well under a thousand cycles; this allows eight thousand
    initial begin
        #200000;
        n_errors++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        t_master();
        chunk_master_on = 1'b1;
        tick(2);
        en(PICK_FRAME, 1'b1);
        en(PICK_TRIG, 1'b1);
        t_frame(1'b1);
        t_clear();
        chunk_master_on = 1'b0;
        tick(2);
        t_frame(1'b0);
        test_done();
    end
endmodule
`default_nettype wire
